// *** src/ss_adc_pkg.sv ***
/*
 package for the single-slope converter timer: register offsets, field positions,
 reset values and timing constants.
 assumes a 10 MHz pclk and an apb master with 32-bit data.
*/
package ss_adc_pkg;
   // ==================================================
   // register byte offsets
   localparam logic [7:0] OFF_MODE = 8'h00;
   localparam logic [7:0] OFF_SYNC_WIDTH = 8'h04;
   localparam logic [7:0] OFF_TRIM = 8'h08;
   localparam logic [7:0] OFF_PERIOD = 8'h0c;
   localparam logic [7:0] OFF_CAP0 = 8'h10;
   localparam logic [7:0] OFF_CAP1 = 8'h14;
   localparam logic [7:0] OFF_CAP2 = 8'h18;
   localparam logic [7:0] OFF_CAP3 = 8'h1c;
   localparam logic [7:0] OFF_STATUS = 8'h20;
   // ==================================================
   // mode control word fields
   localparam int MODE_AUX_LOW_BIT = 0;
   localparam int MODE_AUX_HIGH_BIT = 1;
   localparam int MODE_DOUBLE_BIT = 2;
   localparam int MODE_RATE_BIT = 7;
   // ==================================================
   // widths and reset values
   localparam int CNT_W = 12;
   localparam int TRIM_W = 3;
   localparam int SYNC_W = 8;
   localparam int PERIOD_W = 16;
   localparam int CHANNELS = 4;
   localparam logic [9:0] MODE_RST = 10'h000;
   localparam logic [2:0] TRIM_RST = 3'h0;
   localparam logic [7:0] SYNC_WIDTH_RST = 8'h0a;
   localparam logic [15:0] PERIOD_RST = 16'h0fa0;
   localparam logic [11:0] CNT_MAX = 12'hfff;
   // ==================================================
   // timing
   localparam int CLK_NS = 100;
   localparam int SYNC_MAX_NS = 12500;
   localparam int SYNC_MAX_CYC = SYNC_MAX_NS / CLK_NS;
   localparam int FIFO_DEPTH = 8;
endpackage

// *** src/result_fifo.sv ***
/*
 small flip-flop fifo for capture results.
 assumes one clock, a clock enable and asynchronous active-low reset.
*/
`timescale 1ns/1ps
module result_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 8
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0] cnt_ff;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data = mem_ff[rd_ff];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end
      else if (ce)
      begin
         if (push)
            wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
         if (pop)
            rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge pclk)
   begin
      if (ce && push)
         mem_ff[wr_ff] <= in_data;
   end
endmodule // result_fifo

// *** src/single_slope_adc_timer.sv ***
/*
 single-slope converter timer: sync pulse, shared 12-bit counter, four captures,
 auxiliary select, ramp current trim, apb register slave and a result fifo.
 assumes comparators, ramp and current source outside; comparator levels are async.
*/
// Decided for this implementation: the register offsets and the APB register port.
// Functional notes
// - four channels, three direct, one muxed
// - mode bits 1:0 pick aux input
// - shared 12-bit counter times each crossing
// - sync discharges ramp, clears counter, end starts
// - sync width from programmed register value
// - rate bit 7 picks half or full
// - each capture loads counter on trip
// - counter saturates at 4095
// - double update halves the conversion interval
// - untripped channel reports 0xfff
// - 3-bit trim, reset zero, read/write
`timescale 1ns/1ps
module single_slope_adc_timer
   import ss_adc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [ss_adc_pkg::CHANNELS-1:0] comparator_trip,
   output logic cycle_sync_pulse,
   output logic aux_select_low,
   output logic aux_select_high,
   output logic [ss_adc_pkg::TRIM_W-1:0] ramp_current_trim,
   output logic res_valid,
   input wire logic res_ready,
   output logic [13:0] res_data,
   output logic res_overflow
);
   import ss_adc_pkg::*;

   typedef enum logic [1:0] {st_sync, st_count, st_done} phase_type;

   // ==================================================
   // registers
   logic [9:0] mode_control_word_ff;
   logic [SYNC_W-1:0] sync_width_count_ff;
   logic [TRIM_W-1:0] trim_ff;
   logic [PERIOD_W-1:0] period_ff;
   logic [CNT_W-1:0] cap_ff [CHANNELS];
   logic [CNT_W-1:0] live_ff [CHANNELS];
   logic [CHANNELS-1:0] got_ff;
   logic [CHANNELS-1:0] meta_ff;
   logic [CHANNELS-1:0] trip_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [PERIOD_W-1:0] tick_ff;
   logic [SYNC_W-1:0] sync_cnt_ff;
   logic half_ff;
   logic overflow_ff;
   logic [1:0] drain_ff;
   phase_type phase_ff;
   phase_type nxt_phase;

   // ==================================================
   // decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   wire wr_en = psel && penable && pwrite;
   wire rd_sel = psel && !pwrite;
   wire is_mode = hit(paddr, OFF_MODE);
   wire is_sync = hit(paddr, OFF_SYNC_WIDTH);
   wire is_trim = hit(paddr, OFF_TRIM);
   wire is_per = hit(paddr, OFF_PERIOD);
   wire is_cap = (paddr[7:4] == OFF_CAP0[7:4]) && (paddr[1:0] == 2'b00);
   wire is_stat = hit(paddr, OFF_STATUS);
   wire mapped = is_mode | is_sync | is_trim | is_per | is_cap | is_stat;
   wire [1:0] cap_idx = paddr[3:2];
   wire rate_full = mode_control_word_ff[MODE_RATE_BIT];
   wire double_upd = mode_control_word_ff[MODE_DOUBLE_BIT];
   // half rate counts only every other pclk
   wire tick_en = rate_full || half_ff;
   wire [PERIOD_W-1:0] interval = double_upd ? {1'b0, period_ff[PERIOD_W-1:1]} : period_ff;
   // the done cycle is part of the interval, so the phase ends one tick early
   wire period_end = (tick_ff >= interval - 16'd2);
   wire sync_end = (sync_cnt_ff >= sync_width_count_ff);
   wire at_max = (cnt_ff == CNT_MAX);
   wire [CHANNELS-1:0] new_trip = trip_ff & ~got_ff;

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign cycle_sync_pulse = (phase_ff == st_sync);
   assign aux_select_low = mode_control_word_ff[MODE_AUX_LOW_BIT];
   assign aux_select_high = mode_control_word_ff[MODE_AUX_HIGH_BIT];
   assign ramp_current_trim = trim_ff;
   assign res_overflow = overflow_ff;

   // ==================================================
   // phase sequencing
   always_comb
   begin
      nxt_phase = phase_ff;
      case (phase_ff)
         st_sync: if (sync_end) nxt_phase = st_count;
         st_count: if (period_end) nxt_phase = st_done;
         st_done: nxt_phase = st_sync;
         default: nxt_phase = st_sync;
      endcase
   end

   // ==================================================
   // software registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_control_word_ff <= MODE_RST;
         sync_width_count_ff <= SYNC_WIDTH_RST;
         trim_ff <= TRIM_RST;
         period_ff <= PERIOD_RST;
      end
      else if (ce && wr_en)
      begin
         if (is_mode)
            mode_control_word_ff <= pwdata[9:0];
         if (is_sync)
            sync_width_count_ff <= pwdata[SYNC_W-1:0];
         if (is_trim)
            trim_ff <= pwdata[TRIM_W-1:0];
         if (is_per)
            period_ff <= pwdata[PERIOD_W-1:0];
      end
   end

   // ==================================================
   // read data, registered on the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      else if (ce && rd_sel && !penable)
      begin
         prdata <= '0;
         if (is_mode) prdata <= {22'h0, mode_control_word_ff};
         if (is_sync) prdata <= {24'h0, sync_width_count_ff};
         if (is_trim) prdata <= {29'h0, trim_ff};
         if (is_per) prdata <= {16'h0, period_ff};
         if (is_cap) prdata <= {20'h0, cap_ff[cap_idx]};
         if (is_stat) prdata <= {27'h0, overflow_ff, got_ff};
      end
   end

   // ==================================================
   // comparator synchronisers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_ff <= '0;
         trip_ff <= '0;
      end
      else if (ce)
      begin
         meta_ff <= comparator_trip;
         trip_ff <= meta_ff;
      end
   end

   // ==================================================
   // timer and captures
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase_ff <= st_sync;
         cnt_ff <= '0;
         tick_ff <= '0;
         sync_cnt_ff <= '0;
         half_ff <= 1'b0;
         got_ff <= '0;
      end
      else if (ce)
      begin
         phase_ff <= nxt_phase;
         half_ff <= !half_ff;
         tick_ff <= (phase_ff == st_done) ? '0 : tick_ff + 1'b1;
         if (phase_ff == st_sync)
         begin
            sync_cnt_ff <= sync_cnt_ff + 1'b1;
            cnt_ff <= '0;
            got_ff <= '0;
            half_ff <= 1'b0;
         end
         else
         begin
            sync_cnt_ff <= '0;
            if (phase_ff == st_count && tick_en && !at_max)
               cnt_ff <= cnt_ff + 1'b1;
            if (phase_ff == st_count)
               got_ff <= got_ff | trip_ff;
         end
      end
   end

   // live values per channel, published to software at cycle end
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++)
      begin : chan
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               live_ff[g] <= CNT_MAX;
               cap_ff[g] <= '0;
            end
            else if (ce)
            begin
               if (phase_ff == st_sync)
                  live_ff[g] <= CNT_MAX;
               else if (phase_ff == st_count && new_trip[g])
                  live_ff[g] <= cnt_ff;
               if (phase_ff == st_done)
                  cap_ff[g] <= live_ff[g];
            end
         end
      end
   endgenerate

   // ==================================================
   // result stream: four words per cycle, channel tag in the top bits
   wire fifo_in_ready;
   wire push = (drain_ff != 2'b00) || (phase_ff == st_done);
   wire [1:0] push_idx = (phase_ff == st_done) ? 2'd0 : drain_ff;
   wire [13:0] push_word = {push_idx, (phase_ff == st_done) ? live_ff[0] : cap_ff[push_idx]};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         drain_ff <= 2'b00;
         overflow_ff <= 1'b0;
      end
      else if (ce)
      begin
         if (phase_ff == st_done)
            drain_ff <= 2'd1;
         else if (drain_ff != 2'b00)
            drain_ff <= drain_ff + 1'b1;
         // a full fifo drops the word; sticky flag, cleared by writing status
         if (push && !fifo_in_ready)
            overflow_ff <= 1'b1;
         else if (wr_en && is_stat)
            overflow_ff <= 1'b0;
      end
   end

   result_fifo #(.WIDTH(14), .DEPTH(FIFO_DEPTH)) fifo_i (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(push_word),
      .out_valid(res_valid),
      .out_ready(res_ready),
      .out_data(res_data)
   );
endmodule // single_slope_adc_timer

// *** test/ramp_comparator_model.sv ***
/*
 ramp and four comparators beside the converter timer.
 assumes trips are given as ramp cycles after the sync pulse ends.
*/
`timescale 1ns/1ps
module ramp_comparator_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cycle_sync_pulse,
   input wire logic [3:0][7:0] trip_at,
   output logic [3:0] comparator_trip
);
   // ====================
   // ramp
   logic [9:0] ramp_ff;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn || cycle_sync_pulse)
      begin
         ramp_ff <= '0;
         comparator_trip <= '0;
      end
      else
      begin
         ramp_ff <= ramp_ff + 10'h1;
         // a level stays up until discharge, as a real comparator would
         for (int i = 0; i < 4; i++)
            comparator_trip[i] <= ramp_ff >= {2'h0, trip_at[i]};
      end
   end
endmodule // ramp_comparator_model

// *** test/adc_timer_chk.sv ***
/*
 port checker for the converter timer.
 assumes ss_adc_pkg and one pclk domain.
*/
`timescale 1ns/1ps
module adc_timer_chk
   import ss_adc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cycle_sync_pulse,
   input wire logic aux_select_low,
   input wire logic aux_select_high,
   input wire logic [2:0] ramp_current_trim,
   input wire logic res_valid,
   input wire logic res_ready,
   input wire logic [13:0] res_data,
   input wire logic res_overflow
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ====================
   // helper: programmed width and length of the pulse
   logic [7:0] width_ff;
   logic [8:0] high_ff;
   logic seen_ff;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         width_ff <= SYNC_WIDTH_RST;
         high_ff <= '0;
         seen_ff <= 1'b0;
      end
      else
      begin
         if (psel && penable && pwrite && paddr == OFF_SYNC_WIDTH)
            width_ff <= pwdata[7:0];
         high_ff <= cycle_sync_pulse ? high_ff + 9'h1 : 9'h0;
         // the pulse running at reset release has no known start
         seen_ff <= seen_ff | !cycle_sync_pulse;
      end
   end
   // ====================
   // properties
   sequence s_trim_wr;
      psel && penable && pwrite && ce && paddr == OFF_TRIM;
   endsequence
   sequence s_mode_wr;
      psel && penable && pwrite && ce && paddr == OFF_MODE;
   endsequence
   property p_trim;
      logic [2:0] v;
      (s_trim_wr, v = pwdata[2:0]) |=> ramp_current_trim == v;
   endproperty
   chk_ready_high: assert property (psel |-> pready)
      else $error("pready low");
   chk_unmapped_err: assert property (psel && penable && (paddr > OFF_STATUS ||
      paddr[1:0] != 2'h0) |-> pslverr) else $error("no error on unmapped");
   chk_mapped_ok: assert property (psel && penable && paddr <= OFF_STATUS &&
      paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on mapped");
   chk_trim_load: assert property (p_trim) else $error("trim not loaded");
   chk_aux_select: assert property (s_mode_wr |=> {30'h0, aux_select_high,
      aux_select_low} == ($past(pwdata) & 32'h3)) else $error("aux select wrong");
   chk_sync_width: assert property (seen_ff && $fell(cycle_sync_pulse) |->
      high_ff == {1'b0, width_ff} + 9'h1) else $error("sync length wrong");
   chk_sync_gap: assert property ($fell(cycle_sync_pulse) |->
      !cycle_sync_pulse [*8]) else $error("sync too soon");
   chk_fifo_hold: assert property (res_valid && !res_ready |=>
      res_valid && $stable(res_data)) else $error("result word changed");
   chk_ovf_sticky: assert property (res_overflow && !(psel && penable && pwrite &&
      paddr == OFF_STATUS) |=> res_overflow) else $error("overflow dropped");
endmodule // adc_timer_chk
bind single_slope_adc_timer adc_timer_chk u_chk (.pclk, .presetn, .ce, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .pslverr, .cycle_sync_pulse, .aux_select_low,
   .aux_select_high, .ramp_current_trim, .res_valid, .res_ready, .res_data, .res_overflow);

// *** test/single_slope_adc_timer_tb.sv ***
/*
 testbench for the converter timer: apb tasks, ramp model, result stream.
 assumes the design and ss_adc_pkg are compiled first.
*/
`timescale 1ns/1ps
module single_slope_adc_timer_tb;
   import ss_adc_pkg::*;
   logic pclk, presetn, ce, psel, penable, pwrite, res_ready, err;
   logic pready, pslverr, sync, aux_lo, aux_hi, res_valid, res_overflow;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, c0;
   logic [2:0] trim;
   logic [3:0] trips;
   logic [13:0] res_data;
   logic [3:0][7:0] trip_at;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   int t0;
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;
   single_slope_adc_timer dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .comparator_trip(trips), .cycle_sync_pulse(sync),
      .aux_select_low(aux_lo), .aux_select_high(aux_hi), .ramp_current_trim(trim),
      .res_valid, .res_ready, .res_data, .res_overflow);
   ramp_comparator_model model (.pclk, .presetn, .cycle_sync_pulse(sync), .trip_at,
      .comparator_trip(trips));
   // ====================
   // tasks
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task conv_check(input logic [31:0] d1, input logic [31:0] d2);
      repeat (3) @(posedge sync);
      apb(0, OFF_CAP0, 0);
      c0 = rd;
      apb(0, OFF_CAP1, 0);
      check("cap1 step", rd - c0, d1);
      apb(0, OFF_CAP2, 0);
      check("cap2 step", rd - c0, d2);
      apb(0, OFF_CAP3, 0);
      check("cap3 untripped", rd, {20'h0, CNT_MAX});
   endtask
   task gap(input logic [31:0] mode, input int exp);
      apb(1, OFF_MODE, mode);
      repeat (2) @(posedge sync);
      t0 = cyc;
      @(posedge sync);
      check("sync spacing", cyc - t0, exp);
   endtask
   task finish_test();
      if (fail_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ====================
   // stream monitor: an untripped auxiliary word carries all ones
   always @(posedge pclk)
      if (res_ready && res_valid && res_data[13:12] == 2'h3)
         check("stream aux", res_data[11:0], CNT_MAX);
   initial
   begin
      #(100 * 40000);
      fail_count++;
      finish_test();
   end
   // ====================
   // main sequence
   initial
   begin
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      res_ready = 1'b0;
      trip_at = {8'hff, 8'd24, 8'd16, 8'd10};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1, OFF_SYNC_WIDTH, 32'h4);
      apb(1, OFF_PERIOD, 32'd60);
      apb(0, OFF_TRIM, 0);
      check("trim reset", rd, 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         apb(1, OFF_TRIM, 32'(i));
         apb(0, OFF_TRIM, 0);
         check("trim read", rd, 32'(i));
         check("trim pins", {29'h0, trim}, 32'(i));
      end
      for (int c = 0; c < 4; c++)
      begin
         apb(1, OFF_MODE, 32'h80 | 32'(c));
         @(negedge pclk);
         check("aux pins", {30'h0, aux_hi, aux_lo}, 32'(c));
      end
      apb(1, OFF_TRIM, 32'h0);
      apb(1, OFF_MODE, 32'h83);
      @(negedge pclk);
      check("cal trim", {29'h0, trim}, 32'h0);
      check("cal select", {30'h0, aux_hi, aux_lo}, 32'h3);
      apb(0, 8'h40, 0);
      check("unmapped err", {31'h0, err}, 32'h1);
      check("unmapped data", rd, 32'h0);
      conv_check(32'd6, 32'd14);
      apb(1, OFF_MODE, 32'h0);
      conv_check(32'd3, 32'd7);
      gap(32'h80, 60);
      gap(32'h84, 30);
      check("overflow pin", {31'h0, res_overflow}, 32'h1);
      // read late in the count phase: channels 0 and 1 tripped, 2 is past the end
      @(negedge sync);
      repeat (20) @(posedge pclk);
      apb(0, OFF_STATUS, 0);
      check("status", rd & 32'h1f, 32'h13);
      res_ready <= 1'b1;
      apb(1, OFF_STATUS, 0);
      @(negedge sync);
      repeat (20) @(posedge pclk);
      apb(0, OFF_STATUS, 0);
      check("status cleared", rd & 32'h1f, 32'h03);
      finish_test();
   end
endmodule // single_slope_adc_timer_tb
